// ===== rtl/itpr_relay.sv
// inverse-time protection relay with speed/frequency mismatch check and AXI4-Lite registers
// Functional notes
// - expected frequency is poles times rpm over 120
// - mismatch beyond one hertz held five seconds
// - mismatch action chosen by configuration
// - one curve shape, per-channel shift only
// - timer input is measurement over rated
// - delay is shift times (B plus A/(x^P-1))
// - above rated A 19.61, B 0.491, P 2
// - shift 0.01 to 10.0, default 1.0
// - high sense acts above levels after delay
// - low sense acts below levels after delay
// - at or below rated, fixed shifted ten seconds
// - curve not clipped at ratio five or 25s
// - action only after uninterrupted excursion
// - delay recomputed from present input
// - alarms stay latched until reset
//
// Chosen here: the AXI4-Lite register port and the register addresses.
`timescale 1ns/100ps
`default_nettype none

module itpr_relay (
  // clock and reset
  input  wire logic                    aclk,
  input  wire logic                    aresetn,
  // register bus
  input  wire itpr_pkg::itpr_axil_req_t axil_req,
  output var  itpr_pkg::itpr_axil_rsp_t axil_rsp,
  // measurement front-ends
  input  wire logic                    tick,
  input  wire itpr_pkg::itpr_meas_t     meas,
  // alarm actions
  output logic [itpr_pkg::NCH-1:0]     prealarm,
  output logic [itpr_pkg::NCH-1:0]     alarm,
  output logic                         mismatch,
  output logic                         warn,
  output logic                         trip,
  output logic                         irq
);
  import itpr_pkg::*;

  // trip test without division: elapsed*(x^2-1) >= D*(B*(x^2-1)+A), scaled by rated^2
  function automatic logic expired(input logic [23:0] el, input logic [15:0] m,
                                   input logic [15:0] r, input logic [9:0] d);
    logic [31:0] m2;
    logic [31:0] r2;
    logic [31:0] dm;
    logic [63:0] lhs;
    logic [63:0] rhs;
    m2 = 32'(m) * 32'(m);
    r2 = 32'(r) * 32'(r);
    dm = m2 - r2;
    if (m > r) begin
      lhs = 64'(el) * 64'(SHIFT_SCALE) * 64'(dm);
      rhs = 64'(d) * (64'(CURVE_B_MS) * 64'(dm) + 64'(CURVE_A_MS) * 64'(r2));
    end else begin
      lhs = 64'(el) * 64'(SHIFT_SCALE);
      rhs = 64'(d) * 64'(FIX_B_MS);
    end
    return lhs >= rhs;  // no clip on ratio or delay
  endfunction : expired

  // byte-lane merge for strobed writes
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] strb);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        res[8*i +: 8] = nw[8*i +: 8];
      end
    end
    return res;
  endfunction : merge

  // bus slave state
  logic              aw_q;
  logic [ADDR_W-1:0] awaddr_q;
  logic              w_q;
  logic [31:0]       wdata_q;
  logic [3:0]        wstrb_q;
  logic              bvalid_q;
  logic [1:0]        bresp_q;
  logic              rvalid_q;
  logic [31:0]       rdata_q;
  logic [1:0]        rresp_q;

  // configuration
  logic [5:0]  poles_q;
  itpr_act_t   mm_act_q;
  logic [15:0] rated_q [NCH];
  logic [15:0] pre_q   [NCH];
  logic [15:0] alm_q   [NCH];
  logic [9:0]  shift_q [NCH];
  logic        sense_q [NCH];
  logic [NEV-1:0] irq_stat_q;
  logic [NEV-1:0] mask_q;

  // protection state
  logic [15:0] mm_cnt_q;
  logic        mm_q;
  logic [23:0] elapsed_q [2][NCH];
  logic        flag_q    [2][NCH];
  logic [NCH-1:0] set_pre;
  logic [NCH-1:0] set_alm;
  logic        warn_q;
  logic        trip_q;
  logic        irq_q;

  // handshakes; one write and one read in flight at a time
  wire aw_take = axil_req.awvalid && !aw_q && !bvalid_q;
  wire w_take  = axil_req.wvalid && !w_q && !bvalid_q;
  wire ar_take = axil_req.arvalid && !rvalid_q;
  wire do_wr   = aw_q && w_q && !bvalid_q;

  assign axil_rsp.awready = !aw_q && !bvalid_q;
  assign axil_rsp.wready  = !w_q && !bvalid_q;
  assign axil_rsp.bvalid  = bvalid_q;
  assign axil_rsp.bresp   = bresp_q;
  assign axil_rsp.arready = !rvalid_q;
  assign axil_rsp.rvalid  = rvalid_q;
  assign axil_rsp.rdata   = rdata_q;
  assign axil_rsp.rresp   = rresp_q;

  // write decode
  wire                 wr_ch_hit = (awaddr_q >= ADDR_CH_BASE) && (awaddr_q < ADDR_CH_END);
  wire [ADDR_W-1:0]    wr_ch_rel = awaddr_q - ADDR_CH_BASE;
  wire [ADDR_W-1:0]    wr_ch     = wr_ch_rel >> CH_SHIFT;
  wire [3:0]           wr_off    = awaddr_q[3:0];
  wire                 wr_ok     = wr_ch_hit || awaddr_q == ADDR_CTRL || awaddr_q == ADDR_STATUS
                                   || awaddr_q == ADDR_IRQ || awaddr_q == ADDR_MASK;
  wire [31:0]          ctrl_rd   = {22'h0, mm_act_q, 2'h0, poles_q};
  wire [31:0]          ctrl_new  = merge(ctrl_rd, wdata_q, wstrb_q);
  wire [31:0]          cfg_new   = merge({15'h0, sense_q[wr_ch[0]], 6'h0, shift_q[wr_ch[0]]}, wdata_q, wstrb_q);

  // read decode
  wire                 rd_ch_hit = (axil_req.araddr >= ADDR_CH_BASE) && (axil_req.araddr < ADDR_CH_END);
  wire [ADDR_W-1:0]    rd_ch_rel = axil_req.araddr - ADDR_CH_BASE;
  wire [ADDR_W-1:0]    rd_ch     = rd_ch_rel >> CH_SHIFT;
  wire [NEV-1:0]       status    = {alarm, prealarm, mm_q};
  wire                 rd_irq    = ar_take && axil_req.araddr == ADDR_IRQ;
  logic [31:0]         rd_data;
  logic                rd_ok;

  // read mux
  always_comb begin
    rd_data = 32'h0;
    rd_ok   = 1'b1;
    if (rd_ch_hit) begin
      case (axil_req.araddr[3:0])
        OFF_RATED: rd_data = {16'h0, rated_q[rd_ch[0]]};
        OFF_PRE:   rd_data = {16'h0, pre_q[rd_ch[0]]};
        OFF_ALM:   rd_data = {16'h0, alm_q[rd_ch[0]]};
        OFF_CFG:   rd_data = {15'h0, sense_q[rd_ch[0]], 6'h0, shift_q[rd_ch[0]]};
        default:   rd_ok   = 1'b0;
      endcase
    end else begin
      case (axil_req.araddr)
        ADDR_CTRL:   rd_data = ctrl_rd;
        ADDR_STATUS: rd_data = 32'(status);
        ADDR_IRQ:    rd_data = 32'(irq_stat_q);
        ADDR_MASK:   rd_data = 32'(mask_q);
        default:     rd_ok   = 1'b0;
      endcase
    end
  end

  // write channel capture and response
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_q     <= 1'b0;
      awaddr_q <= '0;
      w_q      <= 1'b0;
      wdata_q  <= 32'h0;
      wstrb_q  <= 4'h0;
      bvalid_q <= 1'b0;
      bresp_q  <= RESP_OKAY;
    end else begin
      if (aw_take) begin
        aw_q     <= 1'b1;
        awaddr_q <= axil_req.awaddr;
      end
      if (w_take) begin
        w_q     <= 1'b1;
        wdata_q <= axil_req.wdata;
        wstrb_q <= axil_req.wstrb;
      end
      if (do_wr) begin
        aw_q     <= 1'b0;
        w_q      <= 1'b0;
        bvalid_q <= 1'b1;
        bresp_q  <= wr_ok ? RESP_OKAY : RESP_SLVERR;
      end else if (bvalid_q && axil_req.bready) begin
        bvalid_q <= 1'b0;
      end
    end
  end

  // read channel
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_q <= 1'b0;
      rdata_q  <= 32'h0;
      rresp_q  <= RESP_OKAY;
    end else if (ar_take) begin
      rvalid_q <= 1'b1;
      rdata_q  <= rd_data;
      rresp_q  <= rd_ok ? RESP_OKAY : RESP_SLVERR;
    end else if (rvalid_q && axil_req.rready) begin
      rvalid_q <= 1'b0;
    end
  end

  // configuration registers; shift writes are clamped into range
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      poles_q  <= POLES_RST;
      mm_act_q <= ACT_TRIP;
      mask_q   <= '0;
      for (int c = 0; c < NCH; c++) begin
        rated_q[c] <= RATED_RST;
        pre_q[c]   <= LVL_RST;
        alm_q[c]   <= LVL_RST;
        shift_q[c] <= SHIFT_RST;
        sense_q[c] <= 1'b0;
      end
    end else if (do_wr) begin
      if (awaddr_q == ADDR_CTRL) begin
        poles_q  <= ctrl_new[CTRL_POLES_LSB +: 6];
        mm_act_q <= itpr_act_t'(ctrl_new[CTRL_ACT_LSB +: 2]);
      end
      if (awaddr_q == ADDR_MASK) begin
        mask_q <= NEV'(merge(32'(mask_q), wdata_q, wstrb_q));
      end
      if (wr_ch_hit) begin
        case (wr_off)
          OFF_RATED: rated_q[wr_ch[0]] <= 16'(merge({16'h0, rated_q[wr_ch[0]]}, wdata_q, wstrb_q));
          OFF_PRE:   pre_q[wr_ch[0]]   <= 16'(merge({16'h0, pre_q[wr_ch[0]]}, wdata_q, wstrb_q));
          OFF_ALM:   alm_q[wr_ch[0]]   <= 16'(merge({16'h0, alm_q[wr_ch[0]]}, wdata_q, wstrb_q));
          OFF_CFG: begin
            sense_q[wr_ch[0]] <= cfg_new[CFG_SENSE_BIT];
            if (cfg_new[CFG_SHIFT_LSB +: 10] < SHIFT_MIN) begin
              shift_q[wr_ch[0]] <= SHIFT_MIN;
            end else if (cfg_new[CFG_SHIFT_LSB +: 10] > SHIFT_MAX) begin
              shift_q[wr_ch[0]] <= SHIFT_MAX;
            end else begin
              shift_q[wr_ch[0]] <= cfg_new[CFG_SHIFT_LSB +: 10];
            end
          end
          default: ;
        endcase
      end
    end
  end

  // speed/frequency mismatch, both sides scaled by 120*100 to avoid division
  wire [31:0] mm_exp   = 32'(poles_q) * 32'(meas.rpm) * 32'(FREQ_SCALE);
  wire [31:0] mm_meas  = 32'(meas.freq_chz) * 32'(POLE_DIV);
  wire [31:0] mm_diff  = (mm_exp > mm_meas) ? mm_exp - mm_meas : mm_meas - mm_exp;
  wire        mm_cond  = mm_diff > 32'(MM_MARGIN);
  wire        mm_set   = mm_cond && tick && !mm_q && mm_cnt_q + 16'h0001 >= 16'(MM_DELAY_TICKS);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mm_cnt_q <= 16'h0;
      mm_q     <= 1'b0;
    end else begin
      if (!mm_cond) begin
        mm_cnt_q <= 16'h0;
      end else if (tick && mm_cnt_q < 16'(MM_DELAY_TICKS)) begin
        mm_cnt_q <= mm_cnt_q + 16'h0001;
      end
      if (mm_set) begin
        mm_q <= 1'b1;
      end
    end
  end

  // one timer per channel and stage: stage 0 pre-alarm, stage 1 alarm
  for (genvar c = 0; c < NCH; c++) begin : g_ch
    for (genvar s = 0; s < 2; s++) begin : g_st
      wire [15:0] lvl    = (s == 1) ? alm_q[c] : pre_q[c];
      wire [15:0] m      = meas.level[c];
      wire        beyond = sense_q[c] ? (m < lvl) : (m > lvl);
      wire        full   = elapsed_q[s][c] > ~24'(TICK_MS);  // stop before the next step would wrap
      wire [23:0] el_inc = full ? elapsed_q[s][c] : elapsed_q[s][c] + 24'(TICK_MS);
      // same curve and shift for every stage; only the level differs
      wire        hit    = beyond && tick && expired(el_inc, m, rated_q[c], shift_q[c]);

      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          elapsed_q[s][c] <= 24'h0;
          flag_q[s][c]    <= 1'b0;
        end else begin
          if (!beyond) begin
            elapsed_q[s][c] <= 24'h0;
          end else if (tick) begin
            elapsed_q[s][c] <= el_inc;
          end
          if (hit) begin
            flag_q[s][c] <= 1'b1;
          end
        end
      end
    end
    assign set_pre[c]  = g_ch[c].g_st[0].hit && !flag_q[0][c];
    assign set_alm[c]  = g_ch[c].g_st[1].hit && !flag_q[1][c];
    assign prealarm[c] = flag_q[0][c];
    assign alarm[c]    = flag_q[1][c];
  end

  assign mismatch = mm_q;

  // events set sticky bits; a set in the clearing cycle wins
  wire [NEV-1:0] events   = {set_alm, set_pre, mm_set};
  wire [NEV-1:0] irq_next = (rd_irq ? '0 : irq_stat_q) | events;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_stat_q <= '0;
      irq_q      <= 1'b0;
      warn_q     <= 1'b0;
      trip_q     <= 1'b0;
    end else begin
      irq_stat_q <= irq_next;
      irq_q      <= |(irq_next & mask_q);
      warn_q     <= (|prealarm) || (mm_q && mm_act_q == ACT_WARN);
      trip_q     <= (|alarm) || (mm_q && mm_act_q == ACT_TRIP);
    end
  end

  assign irq  = irq_q;
  assign warn = warn_q;
  assign trip = trip_q;

endmodule : itpr_relay
`default_nettype wire

// ===== rtl/itpr_pkg.sv
// package: constants, types and register map of the inverse-time protection relay
package itpr_pkg;

  // geometry
  localparam int NCH    = 2;
  localparam int ADDR_W = 8;
  localparam int NEV    = 1 + 2 * NCH;

  // register byte offsets
  localparam logic [ADDR_W-1:0] ADDR_CTRL    = 8'h00;
  localparam logic [ADDR_W-1:0] ADDR_STATUS  = 8'h04;
  localparam logic [ADDR_W-1:0] ADDR_IRQ     = 8'h08;
  localparam logic [ADDR_W-1:0] ADDR_MASK    = 8'h0C;
  localparam logic [ADDR_W-1:0] ADDR_CH_BASE = 8'h10;
  localparam logic [ADDR_W-1:0] ADDR_CH_END  = 8'h30;
  localparam logic [3:0]        OFF_RATED    = 4'h0;
  localparam logic [3:0]        OFF_PRE      = 4'h4;
  localparam logic [3:0]        OFF_ALM      = 4'h8;
  localparam logic [3:0]        OFF_CFG      = 4'hC;
  localparam int                CH_SHIFT     = 4;

  // field positions
  localparam int CTRL_POLES_LSB = 0;
  localparam int CTRL_ACT_LSB   = 8;
  localparam int CFG_SHIFT_LSB  = 0;
  localparam int CFG_SENSE_BIT  = 16;
  localparam int EV_MM          = 0;
  localparam int EV_PRE_BASE    = 1;
  localparam int EV_ALM_BASE    = 1 + NCH;

  // reset values
  localparam logic [5:0]  POLES_RST = 6'h02;
  localparam logic [15:0] LVL_RST   = 16'hFFFF;
  localparam logic [15:0] RATED_RST = 16'h0064;

  // timing, tick period in ms
  localparam int TICK_MS        = 10;
  localparam int MM_DELAY_S     = 5;
  localparam int MM_DELAY_TICKS = MM_DELAY_S * 1000 / TICK_MS;
  localparam int MM_MARGIN_HZ   = 1;
  localparam int FREQ_SCALE     = 100;  // frequency input in 0.01 Hz
  localparam int POLE_DIV       = 120;
  localparam int MM_MARGIN      = MM_MARGIN_HZ * FREQ_SCALE * POLE_DIV;

  // curve constants in ms, exponent two is done by squaring
  localparam int CURVE_A_MS  = 19610;
  localparam int CURVE_B_MS  = 491;
  localparam int FIX_B_MS    = 10000;
  localparam int SHIFT_SCALE = 100;  // shift in hundredths
  localparam logic [9:0] SHIFT_MIN = 10'h001;
  localparam logic [9:0] SHIFT_MAX = 10'h3E8;
  localparam logic [9:0] SHIFT_RST = 10'h064;

  // bus answers
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {ACT_NONE, ACT_WARN, ACT_TRIP} itpr_act_t;

  typedef struct packed {
    logic              awvalid;
    logic [ADDR_W-1:0] awaddr;
    logic              wvalid;
    logic [31:0]       wdata;
    logic [3:0]        wstrb;
    logic              bready;
    logic              arvalid;
    logic [ADDR_W-1:0] araddr;
    logic              rready;
  } itpr_axil_req_t;

  typedef struct packed {
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } itpr_axil_rsp_t;

  typedef struct packed {
    logic [15:0]           rpm;       // speed pickup, rpm
    logic [15:0]           freq_chz;  // generator frequency, 0.01 Hz
    logic [NCH-1:0][15:0]  level;     // protected measurements
  } itpr_meas_t;

endpackage : itpr_pkg

// ===== dv/itpr_meas_src.sv
// behavioural speed pickup, generator meter and controller tick source
`timescale 1ns/100ps
`default_nettype none

module itpr_meas_src (
  // settings from the bench
  input  wire logic               tick_en,
  input  wire logic [15:0]        rpm,
  input  wire logic [15:0]        freq_chz,
  input  wire logic [15:0]        lvl0,
  input  wire logic [15:0]        lvl1,
  // toward the relay
  output var  itpr_pkg::itpr_meas_t meas,
  output logic                    tick
);
  import itpr_pkg::*;

  // front-ends hold a steady reading, so no release pattern is needed
  assign meas.rpm      = rpm;
  assign meas.freq_chz = freq_chz;
  assign meas.level[0] = lvl0;
  assign meas.level[1] = lvl1;
  // tick straight from the bench so tick counts stay exact
  assign tick          = tick_en;
endmodule : itpr_meas_src

`default_nettype wire

// ===== dv/itpr_relay_asserts.sv
// port-level assertions for the protection relay
`timescale 1ns/100ps
`default_nettype none

module itpr_relay_asserts (
  // clock and reset
  input wire logic                     aclk,
  input wire logic                     aresetn,
  // register bus
  input wire itpr_pkg::itpr_axil_req_t axil_req,
  input wire itpr_pkg::itpr_axil_rsp_t axil_rsp,
  // measurements
  input wire logic                     tick,
  input wire itpr_pkg::itpr_meas_t     meas,
  // actions
  input wire logic [itpr_pkg::NCH-1:0] prealarm,
  input wire logic [itpr_pkg::NCH-1:0] alarm,
  input wire logic                     mismatch,
  input wire logic                     warn,
  input wire logic                     trip,
  input wire logic                     irq
);
  import itpr_pkg::*;

  logic [9:0] tcnt_q;
  logic [9:0] tcnt_d;

  // ticks since reset, saturating so it never wraps into a false low count
  assign tcnt_d = (tick && tcnt_q != 10'h3FF) ? tcnt_q + 10'h001 : tcnt_q;
  always_ff @(posedge aclk) begin
    if (!aresetn) tcnt_q <= 10'h000;
    else          tcnt_q <= tcnt_d;
  end

  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);

  AST_ALM_LATCH: assert property ($past(aresetn) |-> ((alarm & $past(alarm)) == $past(alarm)))
    else $error("alarm dropped without reset");
  AST_PRE_LATCH: assert property ($past(aresetn) |-> ((prealarm & $past(prealarm)) == $past(prealarm)))
    else $error("prealarm dropped without reset");
  AST_MM_LATCH: assert property ($past(aresetn) && $past(mismatch) |-> mismatch)
    else $error("mismatch dropped without reset");
  AST_FLAG_ON_TICK: assert property (((prealarm & ~$past(prealarm)) != '0 || (alarm & ~$past(alarm)) != '0
    || $rose(mismatch)) |-> $past(tick)) else $error("flag set without tick");
  AST_MM_DELAY: assert property ($rose(mismatch) |-> tcnt_q >= 10'h1F4)
    else $error("mismatch before 500 ticks");
  AST_WARN_SET: assert property ($past(aresetn) && $past(|prealarm) |-> warn)
    else $error("warn missing after prealarm");
  AST_TRIP_SET: assert property ($past(aresetn) && $past(|alarm) |-> trip)
    else $error("trip missing after alarm");
  AST_WARN_CAUSE: assert property (warn |-> $past(|prealarm) || $past(mismatch))
    else $error("warn without cause");
  AST_B_ONE: assert property (axil_rsp.bvalid && axil_req.bready |=> !axil_rsp.bvalid)
    else $error("write response repeated");
  AST_R_ONE: assert property (axil_rsp.rvalid && axil_req.rready |=> !axil_rsp.rvalid)
    else $error("read response repeated");

  // main scenarios reached
  COV_MM: cover property ($rose(mismatch));
  COV_ALM: cover property ($rose(alarm[1]));
  COV_IRQ_UP: cover property ($rose(irq));
  COV_IRQ_DN: cover property ($fell(irq));
endmodule : itpr_relay_asserts

bind itpr_relay itpr_relay_asserts i_asserts (.aclk, .aresetn, .axil_req, .axil_rsp, .tick, .meas,
  .prealarm, .alarm, .mismatch, .warn, .trip, .irq);

`default_nettype wire

// ===== dv/testbench.sv
// self-checking bench for the protection relay
`timescale 1ns/100ps
`default_nettype none

module testbench;
  import itpr_pkg::*;

  logic           aclk;
  logic           aresetn;
  logic           tick_en;
  logic           tick;
  logic [15:0]    rpm;
  logic [15:0]    freq;
  logic [15:0]    lvl0;
  logic [15:0]    lvl1;
  itpr_axil_req_t req;
  itpr_axil_rsp_t rsp;
  itpr_meas_t     meas;
  logic [NCH-1:0] prealarm;
  logic [NCH-1:0] alarm;
  logic           mismatch;
  logic           warn;
  logic           trip;
  logic           irq;
  logic [1:0]     resp;
  logic [31:0]    rd;
  int             bad_count;
  int             n_checks;

  // 100 MHz clock
  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end

  itpr_meas_src i_src (.tick_en, .rpm, .freq_chz(freq), .lvl0, .lvl1, .meas, .tick);
  itpr_relay i_dut (.aclk, .aresetn, .axil_req(req), .axil_rsp(rsp), .tick, .meas,
    .prealarm, .alarm, .mismatch, .warn, .trip, .irq);

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic give_verdict();
    if (bad_count == 0 && n_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : give_verdict

  function automatic logic [7:0] chad(input int ch, input logic [3:0] off);
    return ADDR_CH_BASE + 8'(ch * 16) + {4'h0, off};
  endfunction : chad

  // handshakes judged on pre-edge values, valid released just after the taking edge, ready left up
  task automatic axw(input logic [7:0] a, input logic [31:0] d);
    logic aw, w, done;
    done = 1'b0;
    req.awvalid <= 1'b1; req.awaddr <= a; req.wvalid <= 1'b1;
    req.wdata <= d; req.wstrb <= 4'hF; req.bready <= 1'b1;
    while (!done) begin
      @(negedge aclk);
      aw = req.awvalid && rsp.awready;
      w = req.wvalid && rsp.wready;
      done = rsp.bvalid;
      resp = rsp.bresp;
      @(posedge aclk);
      if (aw) req.awvalid <= 1'b0;
      if (w) req.wvalid <= 1'b0;
    end
  endtask : axw

  task automatic axr(input logic [7:0] a);
    logic ar, done;
    done = 1'b0;
    req.arvalid <= 1'b1; req.araddr <= a; req.rready <= 1'b1;
    while (!done) begin
      @(negedge aclk);
      ar = req.arvalid && rsp.arready;
      done = rsp.rvalid;
      rd = rsp.rdata;
      resp = rsp.rresp;
      @(posedge aclk);
      if (ar) req.arvalid <= 1'b0;
    end
  endtask : axr

  task automatic do_reset();
    aresetn <= 1'b0; tick_en <= 1'b0; req <= '0;
    rpm <= 16'h05DC; freq <= 16'h09C4; lvl0 <= 16'h0064; lvl1 <= 16'h0064;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
  endtask : do_reset

  // exactly n ticks; returns one tickless edge later, when the flags are settled
  task automatic tick_n(input int n);
    tick_en <= 1'b1;
    repeat (n) @(posedge aclk);
    tick_en <= 1'b0;
    @(posedge aclk);
  endtask : tick_n

  task automatic t_regs();
    axr(ADDR_CTRL); chk(rd, 32'h0000_0202);
    axr(chad(0, OFF_CFG)); chk(rd, 32'h0000_0064);
    axw(chad(0, OFF_CFG), 32'h0000_0000); axr(chad(0, OFF_CFG)); chk(rd, 32'h0000_0001);
    axw(chad(0, OFF_CFG), 32'h0000_03FF); axr(chad(0, OFF_CFG)); chk(rd, 32'h0000_03E8);
    axr(8'hF0); chk(32'(resp), 32'(RESP_SLVERR));
    chk(rd, 32'h0000_0000);
    axw(8'hF0, 32'h0000_0000); chk(32'(resp), 32'(RESP_SLVERR));
  endtask : t_regs

  // four poles at 1500 rpm is 50 Hz; exactly one hertz off must not count
  task automatic t_mismatch();
    for (int a = 0; a < 3; a++) begin
      do_reset();
      axw(ADDR_CTRL, 32'(a << 8) | 32'h0000_0004);
      freq <= 16'h13EC;
      tick_n(600); chk(32'(mismatch), 32'h0);
      freq <= 16'h13ED;
      tick_n(499); chk(32'(mismatch), 32'h0);
      tick_n(1); chk(32'(mismatch), 32'h1);
      @(posedge aclk);
      chk(32'(warn), 32'(a == 1));
      chk(32'(trip), 32'(a == 2));
      chk(32'(irq), 32'h0);
    end
  endtask : t_mismatch

  // one tick back inside restarts the 1618-tick prealarm count
  task automatic t_interrupt();
    do_reset();
    axw(ADDR_MASK, 32'h0000_0002);
    axw(chad(0, OFF_PRE), 32'h0000_0095);
    lvl0 <= 16'h0096; tick_n(1000);
    lvl0 <= 16'h008C; tick_n(1);
    lvl0 <= 16'h0096; tick_n(1617); chk(32'(prealarm[0]), 32'h0);
    tick_n(1); chk(32'(prealarm[0]), 32'h1);
    @(posedge aclk);
    chk(32'(irq), 32'h1);
    axr(ADDR_IRQ); chk(rd, 32'h0000_0002);
    axr(ADDR_IRQ); chk(rd, 32'h0000_0000);
    chk(32'(irq), 32'h0);
    lvl0 <= 16'h0064; tick_n(2); chk(32'(prealarm[0]), 32'h1);
  endtask : t_interrupt

  // flag must rise on exactly the n-th tick, action one cycle later
  task automatic delay_case(input int ch, input logic [15:0] rated, input logic [3:0] off,
                            input logic [15:0] lvl, input logic [31:0] cfg, input logic [15:0] inp, input int n);
    logic is_alm;
    is_alm = (off == OFF_ALM);
    do_reset();
    axw(chad(ch, OFF_RATED), 32'(rated));
    axw(chad(ch, off), 32'(lvl));
    axw(chad(ch, OFF_CFG), cfg);
    if (ch == 0) lvl0 <= inp;
    else lvl1 <= inp;
    tick_n(n - 1); chk(32'(is_alm ? alarm[ch] : prealarm[ch]), 32'h0);
    tick_n(1); chk(32'(is_alm ? alarm[ch] : prealarm[ch]), 32'h1);
    @(posedge aclk);
    chk(32'(is_alm ? trip : warn), 32'h1);
  endtask : delay_case

  initial begin
    bad_count = 0;
    n_checks = 0;
    do_reset();
    t_regs();
    t_mismatch();
    t_interrupt();
    delay_case(0, 16'h0064, OFF_PRE, 16'h0095, 32'h0000_0064, 16'h0096, 1618);
    delay_case(0, 16'h00C8, OFF_PRE, 16'h03E8, 32'h0000_0064, 16'h04B0, 106);
    delay_case(1, 16'h0064, OFF_ALM, 16'h0032, 32'h0001_000A, 16'h0028, 100);
    delay_case(1, 16'h0064, OFF_ALM, 16'h0096, 32'h0000_01F4, 16'h00C8, 3514);
    give_verdict();
  end

  // run needs about 11400 cycles; cut off well beyond that
  initial begin
    #500000;
    bad_count++;
    give_verdict();
  end
endmodule : testbench

`default_nettype wire
